// *** verilog/pifb_regs.svh ***
`ifndef PIFB_REGS_SVH
`define PIFB_REGS_SVH

// ----------------------------------------------------------------
// bus geometry and register offsets (byte addresses)
// ----------------------------------------------------------------
`define PIFB_ADDR_W 5
`define PIFB_DATA_W 32
`define PIFB_FLAG_W 16
`define PIFB_NUM_REGS 3
`define PIFB_OFS_FLAG2 5'h00
`define PIFB_OFS_FLAG3 5'h04
`define PIFB_OFS_FLAG4 5'h08
`define PIFB_OFS_EVT_STAT 5'h0C
`define PIFB_OFS_EVT_MASK 5'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PIFB_FS2_CAPTURE3_BIT 5
`define PIFB_FS2_SERIAL2_EVENT_BIT 1
`define PIFB_FS2_SERIAL2_FAULT_BIT 0
`define PIFB_FS3_CALENDAR_BIT 14
`define PIFB_FS3_TWOWIRE2_MASTER_BIT 2
`define PIFB_FS3_TWOWIRE2_SLAVE_BIT 1
`define PIFB_FS4_CHARGE_TIME_BIT 13
`define PIFB_FS4_VOLTAGE_DETECT_BIT 8
`define PIFB_FS4_CHECKSUM_GEN_BIT 3
`define PIFB_FS4_UART2_ERROR_BIT 2
`define PIFB_FS4_UART1_ERROR_BIT 1

// ----------------------------------------------------------------
// implemented-bit masks and reset values
// ----------------------------------------------------------------
`define PIFB_FS2_IMPL 16'h0023
`define PIFB_FS3_IMPL 16'h4006
`define PIFB_FS4_IMPL 16'h210E
`define PIFB_FLAG_RESET 16'h0000
`define PIFB_EVT_RESET 3'h0

`endif

// *** verilog/pifb_pkg.sv ***
`include "pifb_regs.svh"

package pifb_pkg;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef logic [`PIFB_FLAG_W-1:0] pifb_flag_t;

	// avalon-mm request from the master, signal names as published
	typedef struct packed {
		logic read;
		logic write;
		logic [`PIFB_ADDR_W-1:0] address;
		logic [`PIFB_DATA_W-1:0] writedata;
		logic [3:0] byteenable;
	} pifb_avs_req_t;

	// one-cycle event requests from the peripherals
	typedef struct packed {
		logic capture3_pending;
		logic serial2_event_pending;
		logic serial2_fault_pending;
		logic calendar_pending;
		logic twowire2_master_pending;
		logic twowire2_slave_pending;
		logic charge_time_pending;
		logic voltage_detect_pending;
		logic checksum_gen_pending;
		logic uart2_error_pending;
		logic uart1_error_pending;
	} pifb_events_t;

	// flag words as seen by the rest of the interrupt controller
	typedef struct packed {
		pifb_flag_t flag_status_4;
		pifb_flag_t flag_status_3;
		pifb_flag_t flag_status_2;
	} pifb_flags_t;

	// read handshake phase, one-hot
	typedef enum logic [1:0] {
		PIFB_RD_IDLE = 2'h1,
		PIFB_RD_DONE = 2'h2
	} pifb_rd_state_t;

endpackage

// *** verilog/pifb_flag_reg.sv ***
`timescale 1ns/1ns
`include "pifb_regs.svh"

module pifb_flag_reg #(
	parameter pifb_pkg::pifb_flag_t IMPL = 16'hFFFF
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [1:0] wr_be,
	input wire pifb_pkg::pifb_flag_t wr_data,
	input wire pifb_pkg::pifb_flag_t hw_set,
	output pifb_pkg::pifb_flag_t flag_r
);
	import pifb_pkg::*;

	pifb_flag_t flag_nxt;

	// ----------------------------------------------------------------
	// flag word update
	// ----------------------------------------------------------------
	// software write first, hardware set last so a same-cycle set wins
	always_comb begin
		flag_nxt = flag_r;
		if (wr_en && wr_be[0]) begin
			flag_nxt[7:0] = wr_data[7:0];
		end
		if (wr_en && wr_be[1]) begin
			flag_nxt[15:8] = wr_data[15:8];
		end
		flag_nxt = flag_nxt | hw_set;
		flag_nxt = flag_nxt & IMPL;
	end

	// plain storage, zero after reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_r <= `PIFB_FLAG_RESET;
		end else begin
			flag_r <= flag_nxt;
		end
	end

endmodule

// *** verilog/pifb_flag_bank.sv ***
`timescale 1ns/1ns
`include "pifb_regs.svh"

module pifb_flag_bank (
	input wire logic clk,
	input wire logic rst_b,
	input wire pifb_pkg::pifb_avs_req_t avs_req,
	output logic [`PIFB_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire pifb_pkg::pifb_events_t events,
	output pifb_pkg::pifb_flags_t flags,
	output logic irq
);
	import pifb_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam pifb_flag_t IMPL [`PIFB_NUM_REGS] = '{
		`PIFB_FS2_IMPL, `PIFB_FS3_IMPL, `PIFB_FS4_IMPL
	};
	localparam logic [`PIFB_ADDR_W-1:0] OFS [`PIFB_NUM_REGS] = '{
		`PIFB_OFS_FLAG2, `PIFB_OFS_FLAG3, `PIFB_OFS_FLAG4
	};

	pifb_flag_t hw_set [`PIFB_NUM_REGS];
	pifb_flag_t flag_q [`PIFB_NUM_REGS];
	logic [`PIFB_NUM_REGS-1:0] flag_wr;
	logic [`PIFB_NUM_REGS-1:0] evt_hit;
	logic [`PIFB_NUM_REGS-1:0] evt_stat_r;
	logic [`PIFB_NUM_REGS-1:0] evt_stat_nxt;
	logic [`PIFB_NUM_REGS-1:0] evt_mask_r;
	logic [`PIFB_NUM_REGS-1:0] evt_mask_nxt;
	logic [`PIFB_DATA_W-1:0] rd_mux;
	logic [`PIFB_DATA_W-1:0] readdata_r;
	logic [`PIFB_DATA_W-1:0] readdata_nxt;
	logic wr_go;
	logic wr_lo;
	pifb_rd_state_t rd_state_r;
	pifb_rd_state_t rd_state_nxt;

	// ----------------------------------------------------------------
	// event routing to flag positions
	// ----------------------------------------------------------------
	// each source lands on its own bit; every other position stays low
	always_comb begin
		for (int i = 0; i < `PIFB_NUM_REGS; i++) begin
			hw_set[i] = `PIFB_FLAG_RESET;
		end
		hw_set[0][`PIFB_FS2_CAPTURE3_BIT] = events.capture3_pending;
		hw_set[0][`PIFB_FS2_SERIAL2_EVENT_BIT] = events.serial2_event_pending;
		hw_set[0][`PIFB_FS2_SERIAL2_FAULT_BIT] = events.serial2_fault_pending;
		hw_set[1][`PIFB_FS3_CALENDAR_BIT] = events.calendar_pending;
		hw_set[1][`PIFB_FS3_TWOWIRE2_MASTER_BIT] = events.twowire2_master_pending;
		hw_set[1][`PIFB_FS3_TWOWIRE2_SLAVE_BIT] = events.twowire2_slave_pending;
		hw_set[2][`PIFB_FS4_UART2_ERROR_BIT] = events.uart2_error_pending;
		hw_set[2][`PIFB_FS4_CHARGE_TIME_BIT] = events.charge_time_pending;
		hw_set[2][`PIFB_FS4_VOLTAGE_DETECT_BIT] = events.voltage_detect_pending;
		hw_set[2][`PIFB_FS4_CHECKSUM_GEN_BIT] = events.checksum_gen_pending;
		hw_set[2][`PIFB_FS4_UART1_ERROR_BIT] = events.uart1_error_pending;
	end

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	// writes never stall, so a write lands on the edge it is presented
	assign wr_go = avs_req.write && !avs_req.read;
	assign wr_lo = wr_go && avs_req.byteenable[0];

	// ----------------------------------------------------------------
	// the three flag words
	// ----------------------------------------------------------------
	generate
		for (genvar g = 0; g < `PIFB_NUM_REGS; g++) begin : g_flag
			assign flag_wr[g] = wr_go && (avs_req.address == OFS[g]);
			assign evt_hit[g] = |hw_set[g];
			pifb_flag_reg #(
				.IMPL(IMPL[g])
			) u_flag (
				.clk(clk),
				.rst_b(rst_b),
				.wr_en(flag_wr[g]),
				.wr_be(avs_req.byteenable[1:0]),
				.wr_data(avs_req.writedata[`PIFB_FLAG_W-1:0]),
				.hw_set(hw_set[g]),
				.flag_r(flag_q[g])
			);
		end
	endgenerate

	assign flags.flag_status_2 = flag_q[0];
	assign flags.flag_status_3 = flag_q[1];
	assign flags.flag_status_4 = flag_q[2];

	// ----------------------------------------------------------------
	// event summary status and mask
	// ----------------------------------------------------------------
	// one sticky bit per flag word, write one to clear; a new event in
	// the clearing cycle keeps the bit set so no event slips past
	always_comb begin
		evt_stat_nxt = evt_stat_r;
		evt_mask_nxt = evt_mask_r;
		if (wr_lo && avs_req.address == `PIFB_OFS_EVT_STAT) begin
			evt_stat_nxt = evt_stat_r & ~avs_req.writedata[`PIFB_NUM_REGS-1:0];
		end
		if (wr_lo && avs_req.address == `PIFB_OFS_EVT_MASK) begin
			evt_mask_nxt = avs_req.writedata[`PIFB_NUM_REGS-1:0];
		end
		evt_stat_nxt = evt_stat_nxt | evt_hit;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			evt_stat_r <= `PIFB_EVT_RESET;
			evt_mask_r <= `PIFB_EVT_RESET;
		end else begin
			evt_stat_r <= evt_stat_nxt;
			evt_mask_r <= evt_mask_nxt;
		end
	end

	// level output, high while any unmasked summary bit is set
	assign irq = |(evt_stat_r & evt_mask_r);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// unmapped offsets and unimplemented positions read as zero
	always_comb begin
		rd_mux = '0;
		unique case (avs_req.address)
			`PIFB_OFS_FLAG2: rd_mux[`PIFB_FLAG_W-1:0] = flag_q[0];
			`PIFB_OFS_FLAG3: rd_mux[`PIFB_FLAG_W-1:0] = flag_q[1];
			`PIFB_OFS_FLAG4: rd_mux[`PIFB_FLAG_W-1:0] = flag_q[2];
			`PIFB_OFS_EVT_STAT: rd_mux[`PIFB_NUM_REGS-1:0] = evt_stat_r;
			`PIFB_OFS_EVT_MASK: rd_mux[`PIFB_NUM_REGS-1:0] = evt_mask_r;
			default: rd_mux = '0;
		endcase
	end

	// one wait cycle per read buys registered read data with no
	// combinational path from the flags to the bus
	always_comb begin
		rd_state_nxt = rd_state_r;
		readdata_nxt = readdata_r;
		unique case (rd_state_r)
			PIFB_RD_IDLE: begin
				if (avs_req.read) begin
					rd_state_nxt = PIFB_RD_DONE;
					readdata_nxt = rd_mux;
				end
			end
			PIFB_RD_DONE: begin
				rd_state_nxt = PIFB_RD_IDLE;
			end
			default: begin
				rd_state_nxt = PIFB_RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_state_r <= PIFB_RD_IDLE;
			readdata_r <= '0;
		end else begin
			rd_state_r <= rd_state_nxt;
			readdata_r <= readdata_nxt;
		end
	end

	assign avs_readdata = readdata_r;
	assign avs_waitrequest = avs_req.read && (rd_state_r == PIFB_RD_IDLE);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence rd_issue_s;
		avs_req.read && avs_waitrequest;
	endsequence

	sequence rd_done_s;
		avs_req.read && !avs_waitrequest;
	endsequence

	// a read is answered exactly one cycle after it is presented
	read_answer_time_a: assert property (
		rd_issue_s |=> (!avs_req.read || !avs_waitrequest)
	) else $error("read not answered after one wait cycle");

	// data answered equals the flag word seen when the read was taken
	read_data_match_a: assert property (
		(rd_issue_s and (avs_req.address == `PIFB_OFS_FLAG2))
		##1 rd_done_s |-> avs_readdata == {16'h0000, $past(flag_q[0])}
	) else $error("flag word 2 read back wrong");

	// upper half of every answered read is zero
	upper_zero_a: assert property (
		rd_done_s |-> avs_readdata[31:16] == 16'h0000
	) else $error("read data upper half not zero");

	// writes never stall the bus
	write_nowait_a: assert property (
		(avs_req.write && !avs_req.read) |-> !avs_waitrequest
	) else $error("write stalled");

	// words are zero in the cycle right after reset release
	reset_zero_a: assert property (
		$rose(rst_b) |-> (flag_q[0] == 16'h0000 && flag_q[1] == 16'h0000
			&& flag_q[2] == 16'h0000)
	) else $error("flag word not zero after reset");

	// software write of a one is stored at the next edge
	write_store_a: assert property (
		(flag_wr[2] && avs_req.byteenable[0] && avs_req.writedata[1])
		|=> flag_q[2][1]
	) else $error("flag write not stored");

	generate
		for (genvar a = 0; a < `PIFB_NUM_REGS; a++) begin : g_chk
			// unimplemented positions never show a one
			unimpl_zero_a: assert property (
				(flag_q[a] & ~IMPL[a]) == 16'h0000
			) else $error("unimplemented flag bit set");

			// a flag turns on only from its event or a write of one
			rise_cause_a: assert property (
				(flag_q[a] & ~$past(flag_q[a])) != 16'h0000 |->
				($past(hw_set[a]) != 16'h0000 || $past(flag_wr[a]))
			) else $error("flag set without a cause");

			// an event always leaves its summary bit set, even against a clear
			summary_set_a: assert property (
				evt_hit[a] |=> evt_stat_r[a]
			) else $error("summary bit missed an event");

			// a flag with no write and no event keeps its value
			flag_hold_a: assert property (
				(!flag_wr[a] && hw_set[a] == 16'h0000) |=>
				flag_q[a] == $past(flag_q[a])
			) else $error("flag changed without a cause");
		end
	endgenerate

	capture3_set_a: assert property (
		events.capture3_pending |=> flag_q[0][5]
	) else $error("capture 3 flag not set");

	serial2_evt_a: assert property (
		events.serial2_event_pending |=> flag_q[0][1]
	) else $error("serial2 event flag not set");

	serial2_fault_a: assert property (
		events.serial2_fault_pending |=> flag_q[0][0]
	) else $error("serial2 fault flag not set");

	calendar_set_a: assert property (
		events.calendar_pending |=> flag_q[1][14]
	) else $error("calendar flag not set");

	twowire_master_a: assert property (
		events.twowire2_master_pending |=> flag_q[1][2]
	) else $error("twowire2 master flag not set");

	twowire_slave_a: assert property (
		events.twowire2_slave_pending |=> flag_q[1][1]
	) else $error("twowire2 slave flag not set");

	uart2_error_a: assert property (
		events.uart2_error_pending |=> flag_q[2][2]
	) else $error("uart2 error flag not set");

	charge_time_a: assert property (
		events.charge_time_pending |=> flag_q[2][13]
	) else $error("charge time flag not set");

	voltage_det_a: assert property (
		events.voltage_detect_pending |=> flag_q[2][8]
	) else $error("voltage detect flag not set");

	checksum_set_a: assert property (
		events.checksum_gen_pending |=> flag_q[2][3]
	) else $error("checksum flag not set");

	uart1_error_a: assert property (
		events.uart1_error_pending |=> flag_q[2][1]
	) else $error("uart1 error flag not set");

	// clearing write racing an event leaves the flag set
	set_wins_a: assert property (
		(flag_wr[0] && avs_req.byteenable[0] && events.capture3_pending)
		|=> flag_q[0][5]
	) else $error("event lost to a clearing write");

	// interrupt follows the masked summary with the register delay
	irq_follow_a: assert property (
		(evt_hit[0] && evt_mask_r[0]) ##1 evt_mask_r[0] |-> irq
	) else $error("interrupt not raised for masked-in event");

	// with the mask clear the interrupt stays low
	irq_masked_a: assert property (
		evt_mask_r == 3'h0 |-> !irq
	) else $error("interrupt raised while fully masked");

endmodule

// *** tb/pifb_event_src.sv ***
`timescale 1ns/1ns

// ----------------------------------------------------------------
// stand-in for the peripherals that raise event requests
// ----------------------------------------------------------------
module pifb_event_src (
	input wire logic clk,
	output pifb_pkg::pifb_events_t events
);
	import pifb_pkg::*;

	// lines idle low from time zero so no request is seen during reset
	initial begin
		events = '0;
	end

	// raise one request line for some cycles; held lines keep re-setting
	task automatic fire(input int idx, input int cycles);
		events <= pifb_events_t'(11'h001 << idx);
		repeat (cycles) @(posedge clk);
		events <= '0;
	endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ns
`include "pifb_regs.svh"

module tb;
	import pifb_pkg::*;

	// ----------------------------------------------------------------
	// bench state
	// ----------------------------------------------------------------
	logic clk;
	logic rst_b;
	pifb_avs_req_t req;
	logic [31:0] rdata;
	logic wait_req;
	pifb_events_t ev;
	pifb_flags_t flags;
	logic irq;
	int error_cnt = 0;
	int compares = 0;
	logic [31:0] got;
	// word and bit reached by each event line, index is the packed position
	int ev_word [11] = '{2, 2, 2, 2, 2, 1, 1, 1, 0, 0, 0};
	int ev_bit [11] = '{1, 2, 3, 8, 13, 1, 2, 14, 0, 1, 5};
	logic [15:0] impl [3] = '{16'h0023, 16'h4006, 16'h210E};

	pifb_flag_bank dut_u (
		.clk(clk),
		.rst_b(rst_b),
		.avs_req(req),
		.avs_readdata(rdata),
		.avs_waitrequest(wait_req),
		.events(ev),
		.flags(flags),
		.irq(irq)
	);

	pifb_event_src ev_u (
		.clk(clk),
		.events(ev)
	);

	// free-running system clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] seen);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one avalon transfer; an extra edge after release keeps drivers apart
	task automatic bus(input logic rd, input logic [4:0] adr, input logic [31:0] dat,
		input logic [3:0] be);
		int n = 0;
		req.read <= rd;
		req.write <= ~rd;
		req.address <= adr;
		req.writedata <= dat;
		req.byteenable <= be;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0);
		got = rdata;
		chk("bus wait cycles", rd ? 2 : 1, n);
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
		bus(1'b0, adr, dat, 4'hF);
	endtask

	task automatic rd_chk(input string what, input logic [4:0] adr, input logic [31:0] exp);
		bus(1'b1, adr, 32'h0, 4'hF);
		chk(what, exp, got);
	endtask

	// look at level outputs mid-cycle, then return to the edge
	task automatic port_chk(input logic [47:0] exp_flags, input logic exp_irq);
		@(negedge clk);
		chk("flags port", exp_flags, flags);
		chk("irq", exp_irq, irq);
		@(posedge clk);
	endtask

	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// watchdog sized well above the few hundred cycles the tests need
	initial begin
		#400000;
		error_cnt++;
		$display("ERROR watchdog expected done seen hang");
		wrap_up();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		req = '0;
		rst_b = 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);

		// everything reads zero out of reset
		for (int a = 0; a < 5; a++) begin
			rd_chk("reset value", 5'(a * 4), 32'h0);
		end
		port_chk(48'h0, 1'b0);
		$display("test reset done");

		// all ones written: only implemented bits stick, then clear by zero
		for (int w = 0; w < 3; w++) begin
			wr(5'(w * 4), 32'hFFFFFFFF);
			rd_chk("written ones", 5'(w * 4), {16'h0, impl[w]});
			port_chk(48'(impl[w]) << (w * 16), 1'b0);
			wr(5'(w * 4), 32'h0);
			rd_chk("written zero", 5'(w * 4), 32'h0);
		end
		bus(1'b0, 5'h08, 32'h0000FFFF, 4'h1);
		rd_chk("low byte only", 5'h08, 32'h0000000E);
		bus(1'b0, 5'h08, 32'h0000FFFF, 4'h2);
		rd_chk("high byte added", 5'h08, 32'h0000210E);
		wr(5'h08, 32'h0);
		wr(5'h14, 32'hFFFFFFFF);
		rd_chk("unmapped", 5'h14, 32'h0);
		port_chk(48'h0, 1'b0);
		$display("test access done");

		// each event line lands on its own bit and nowhere else
		for (int i = 0; i < 11; i++) begin
			ev_u.fire(i, 1 + i % 3);
			port_chk(48'h1 << (ev_word[i] * 16 + ev_bit[i]), 1'b0);
			rd_chk("flag word", 5'(ev_word[i] * 4), 32'h1 << ev_bit[i]);
			rd_chk("summary", 5'h0C, 32'h1 << ev_word[i]);
			wr(5'(ev_word[i] * 4), 32'h0);
			wr(5'h0C, 32'h1 << ev_word[i]);
			rd_chk("flag cleared", 5'(ev_word[i] * 4), 32'h0);
		end
		rd_chk("summary cleared", 5'h0C, 32'h0);
		$display("test events done");

		// a set in the cycle of a clearing write is not lost
		fork
			wr(5'h00, 32'h0);
			ev_u.fire(10, 1);
		join
		rd_chk("set beats clear", 5'h00, 32'h00000020);
		wr(5'h00, 32'h0);
		$display("test collision done");

		// interrupt raised, masked, unmasked and cleared
		wr(5'h10, 32'h1);
		port_chk(48'h0, 1'b1);
		wr(5'h10, 32'h0);
		port_chk(48'h0, 1'b0);
		wr(5'h10, 32'h1);
		wr(5'h0C, 32'h1);
		port_chk(48'h0, 1'b0);
		ev_u.fire(7, 1);
		port_chk(48'h1 << 30, 1'b0);
		rd_chk("summary word3", 5'h0C, 32'h2);
		wr(5'h10, 32'h7);
		port_chk(48'h1 << 30, 1'b1);
		rd_chk("mask", 5'h10, 32'h7);
		wr(5'h04, 32'h0);
		wr(5'h0C, 32'h2);
		port_chk(48'h0, 1'b0);
		$display("test interrupt done");

		// masked-in event raises the interrupt; reset in mid-run clears all
		ev_u.fire(9, 1);
		port_chk(48'h2, 1'b1);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		port_chk(48'h0, 1'b0);
		rd_chk("summary after reset", 5'h0C, 32'h0);
		rd_chk("mask after reset", 5'h10, 32'h0);
		$display("test midrun reset done");

		wrap_up();
	end
endmodule
